// file: shared/scan_seq_pkg.sv
`default_nettype none
package scan_seq_pkg;
  // Scan step grid and derived cycle counts at 250 MHz.
  localparam int unsigned CLK_FREQ_HZ      = 250_000_000;
  localparam int unsigned STEP_TIME_US     = 1000;
  localparam int unsigned STEP_CYCLES      = (CLK_FREQ_HZ / 1_000_000) * STEP_TIME_US;
  localparam int unsigned STEP_CNT_W       = 18;
  localparam int unsigned MIN_TRIG_TIME_NS = 1000;
  localparam int unsigned MIN_TRIG_CYCLES  = (MIN_TRIG_TIME_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned DUR_W            = 24;
  localparam int unsigned VOLT_W           = 21;

  // Reset-cause codes shown on the display.
  localparam logic [3:0] RC_NONE       = 4'h0;
  localparam logic [3:0] RC_UNDERVOLT  = 4'h1;
  localparam logic [3:0] RC_CLOCK      = 4'h2;
  localparam logic [3:0] RC_WATCHDOG   = 4'h3;
  localparam logic [3:0] RC_PIN        = 4'h4;
  localparam logic [3:0] RC_DEBUG_PORT = 4'h7;
  localparam logic [3:0] RC_FIRMWARE   = 4'h8;
  localparam logic [3:0] RC_PROG_PORT  = 4'hA;
  localparam logic [3:0] RC_TAMPER     = 4'hB;
  localparam logic [3:0] RC_UNKNOWN    = 4'hC;
  localparam logic [3:0] RC_LOCKUP     = 4'hD;
  localparam logic [3:0] RC_STOP_ACK   = 4'hE;

  // Reset-cause source bit positions.
  localparam int unsigned RS_UNDERVOLT  = 0;
  localparam int unsigned RS_CLOCK      = 1;
  localparam int unsigned RS_WATCHDOG   = 2;
  localparam int unsigned RS_PIN        = 3;
  localparam int unsigned RS_DEBUG_PORT = 4;
  localparam int unsigned RS_FIRMWARE   = 5;
  localparam int unsigned RS_PROG_PORT  = 6;
  localparam int unsigned RS_TAMPER     = 7;
  localparam int unsigned RS_LOCKUP     = 8;
  localparam int unsigned RS_STOP_ACK   = 9;
  localparam int unsigned RS_W          = 10;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_ARMED   = 3'b010,
    ST_RUNNING = 3'b100
  } scan_state_e;
endpackage
`default_nettype wire

// file: hdl/trig_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none
module trig_edge_detect (
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic ext_start_n,
  output logic      fall_pulse
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      prev_ff <= 1'b1;
    end else begin
      meta_ff <= ext_start_n;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // Falling edge from two consecutive synchronised samples.
  assign fall_pulse = prev_ff & ~sync_ff;
endmodule // trig_edge_detect
`default_nettype wire

// file: hdl/scan_sequencer.sv
// Functional notes
// - External start is active low; a falling edge starts an armed scan.
// - External start edges count only while armed.
// - Busy output stays high while idle or armed.
// - Busy output stays low for the whole running scan.
// - Busy output goes low one clock after a start button or remote start, three clocks after an external start edge.
// - Running scan steps align to the 1 ms scan grid.
// - Single shot ends after one duration, or two when bidirectional.
// - Repeating scan runs until a halt request.
// - Cancel or remote idle request halts a running scan anytime.
// - Halt keeps output at last scan value and leaves it enabled.
// - Arm refused with range error when ranges differ.
// - Arm refused with output-off error when output disabled.
// - Arm refused with equal-endpoints error when begin equals end.
// - Interlock opening on high range with output on latches an error.
// - Reset cause reported as its numeric code.
// - Reset-cause code holds until cancel, then operation resumes.
// - Corrupt configuration error clears on a button, then defaults load.
// - Corrupt calibration error clears on a button, then nominal scale loads.
// - Out-of-range calibration adjustment is discarded with an error.
// - Failed program memory check blocks normal operation.
// - Further external start edges are ignored while running.
// - Successful arm sets output to begin voltage and waits armed.
// - Output advances one amplitude step per 1 ms slot.
`timescale 1ns/1ps
`default_nettype none
module scan_sequencer
  import scan_seq_pkg::*;
#(
  parameter int unsigned STEP_CYC = STEP_CYCLES,
  parameter int unsigned VW       = VOLT_W,
  parameter int unsigned DW       = DUR_W
) (
  input  wire logic                  core_clk,
  input  wire logic                  arst_n,
  input  wire logic                  ext_start_n,
  input  wire logic                  start_btn,
  input  wire logic                  start_remote,
  input  wire logic                  scan_arm_state_cmd,
  input  wire logic                  cancel_btn,
  input  wire logic                  idle_remote,
  input  wire logic                  any_btn,
  input  wire logic                  remote_data,
  input  wire logic                  output_on,
  input  wire logic [1:0]            output_range,
  input  wire logic [1:0]            scan_range,
  input  wire logic                  bidir,
  input  wire logic                  repeat_mode,
  input  wire logic [VW-1:0]         v_begin,
  input  wire logic [VW-1:0]         v_end,
  input  wire logic [VW-1:0]         v_step,
  input  wire logic [DW-1:0]         duration_ms,
  input  wire logic                  interlock_closed,
  input  wire logic                  cal_adjust_req,
  input  wire logic                  cal_adjust_ovr,
  input  wire logic                  cfg_corrupt,
  input  wire logic                  cal_corrupt,
  input  wire logic                  prog_check_ok,
  input  wire logic                  selftest_done,
  input  wire logic [RS_W-1:0]       reset_src,
  output logic                       busy_n,
  output logic                       armed,
  output logic [VW-1:0]              v_out,
  output logic                       v_out_en,
  output logic                       err_range,
  output logic                       err_out_off,
  output logic                       err_equal,
  output logic                       err_interlock,
  output logic                       err_cfg,
  output logic                       err_cal,
  output logic                       err_cal_adj,
  output logic                       err_prog,
  output logic [3:0]                 reset_code,
  output logic                       load_defaults,
  output logic                       load_nominal,
  output logic                       cal_commit,
  output logic                       normal_op
);
  localparam logic [1:0] RANGE_HIGH = 2'h2;

  scan_state_e           state_ff, nxt_state;
  logic [STEP_CNT_W-1:0] step_cnt_ff;
  logic [DW:0]           slot_ff;
  logic                  down_ff;
  logic [VW-1:0]         v_out_ff;
  logic [3:0]            rc_ff;
  logic                  pwr_done_ff;
  logic                  ext_fall;

  trig_edge_detect u_trig (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .ext_start_n(ext_start_n),
    .fall_pulse (ext_fall)
  );

  function automatic logic [3:0] cause_code(input logic [RS_W-1:0] s);
    if (s[RS_UNDERVOLT]) return RC_UNDERVOLT;
    else if (s[RS_CLOCK]) return RC_CLOCK;
    else if (s[RS_WATCHDOG]) return RC_WATCHDOG;
    else if (s[RS_PIN]) return RC_PIN;
    else if (s[RS_DEBUG_PORT]) return RC_DEBUG_PORT;
    else if (s[RS_FIRMWARE]) return RC_FIRMWARE;
    else if (s[RS_PROG_PORT]) return RC_PROG_PORT;
    else if (s[RS_TAMPER]) return RC_TAMPER;
    else if (s[RS_LOCKUP]) return RC_LOCKUP;
    else if (s[RS_STOP_ACK]) return RC_STOP_ACK;
    else return RC_UNKNOWN;
  endfunction

  wire ops_ok     = normal_op & (rc_ff == RC_NONE);
  wire range_bad  = output_range != scan_range;
  wire off_bad    = ~output_on;
  wire equal_bad  = v_begin == v_end;
  wire arm_try    = ops_ok & scan_arm_state_cmd & (state_ff == ST_IDLE);
  wire arm_ok     = arm_try & ~range_bad & ~off_bad & ~equal_bad;
  wire start_any  = (state_ff == ST_ARMED) & (start_btn | start_remote | ext_fall);
  wire halt_req   = cancel_btn | idle_remote;
  wire slot_tick  = step_cnt_ff == STEP_CNT_W'(STEP_CYC - 1);
  wire [DW:0] total_slots = bidir ? {duration_ms, 1'b0} : {1'b0, duration_ms};
  wire last_slot  = slot_tick & (slot_ff + 1'b1 >= total_slots);
  wire natural_end = last_slot & ~repeat_mode;
  wire half_turn  = slot_tick & bidir & (slot_ff + 1'b1 == {1'b0, duration_ms});

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (arm_ok) nxt_state = ST_ARMED;
      end
      ST_ARMED: begin
        if (cancel_btn | idle_remote) nxt_state = ST_IDLE;
        else if (start_any) nxt_state = ST_RUNNING;
      end
      ST_RUNNING: begin
        if (halt_req | natural_end) nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Step voltage toward the current target, clamping at the endpoint.
  function automatic logic [VW-1:0] step_to(input logic [VW-1:0] v, input logic [VW-1:0] tgt,
                                            input logic [VW-1:0] st);
    logic signed [VW:0] d;
    d = $signed({tgt[VW-1], tgt}) - $signed({v[VW-1], v});
    if (d > $signed({1'b0, st})) return VW'(v + st);
    else if (-d > $signed({1'b0, st})) return VW'(v - st);
    else return tgt;
  endfunction

  wire [VW-1:0] tgt = down_ff ? v_begin : v_end;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_IDLE;
      busy_n   <= 1'b1;
      armed    <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      busy_n   <= ~(nxt_state == ST_RUNNING);
      armed    <= nxt_state == ST_ARMED;
    end
  end

  // The slot counter restarts at the start, putting steps on a 1 ms grid.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      step_cnt_ff <= '0;
      slot_ff     <= '0;
      down_ff     <= 1'b0;
    end else if (state_ff != ST_RUNNING) begin
      step_cnt_ff <= '0;
      slot_ff     <= '0;
      down_ff     <= 1'b0;
    end else if (slot_tick) begin
      step_cnt_ff <= '0;
      slot_ff     <= last_slot ? '0 : slot_ff + 1'b1;
      down_ff     <= last_slot ? 1'b0 : (half_turn ? 1'b1 : down_ff);
    end else begin
      step_cnt_ff <= step_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      v_out_ff <= '0;
    end else if (arm_ok) begin
      v_out_ff <= v_begin;
    end else if (state_ff == ST_RUNNING && slot_tick && !halt_req) begin
      v_out_ff <= (last_slot & repeat_mode & ~bidir) ? v_begin : step_to(v_out_ff, tgt, v_step);
    end
  end
  // Halting never touches the value or enable, so both hold.
  assign v_out = v_out_ff;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      v_out_en <= 1'b0;
    end else begin
      v_out_en <= output_on;
    end
  end

  // Arm errors are one-cycle pulses on a refused attempt.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      err_range   <= 1'b0;
      err_out_off <= 1'b0;
      err_equal   <= 1'b0;
      err_cal_adj <= 1'b0;
      cal_commit  <= 1'b0;
    end else begin
      err_range   <= arm_try & range_bad;
      err_out_off <= arm_try & off_bad;
      err_equal   <= arm_try & equal_bad;
      err_cal_adj <= cal_adjust_req & cal_adjust_ovr;
      cal_commit  <= cal_adjust_req & ~cal_adjust_ovr;
    end
  end

  wire ilk_event = output_on & (output_range == RANGE_HIGH) & ~interlock_closed;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      err_interlock <= 1'b0;
    end else if (ilk_event) begin
      err_interlock <= 1'b1;
    end else if (any_btn | remote_data) begin
      err_interlock <= 1'b0;
    end
  end

  // Power-up checks: sampled once when self-test completes.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_done_ff   <= 1'b0;
      err_cfg       <= 1'b0;
      err_cal       <= 1'b0;
      err_prog      <= 1'b0;
      rc_ff         <= RC_NONE;
      load_defaults <= 1'b0;
      load_nominal  <= 1'b0;
      normal_op     <= 1'b0;
    end else begin
      load_defaults <= 1'b0;
      load_nominal  <= 1'b0;
      if (!pwr_done_ff && selftest_done) begin
        pwr_done_ff <= 1'b1;
        err_prog    <= ~prog_check_ok;
        err_cfg     <= cfg_corrupt;
        err_cal     <= cal_corrupt;
        rc_ff       <= (reset_src != '0) ? cause_code(reset_src) : RC_NONE;
      end else if (pwr_done_ff && !err_prog) begin
        if (err_cfg && any_btn) begin
          err_cfg       <= 1'b0;
          load_defaults <= 1'b1;
        end
        if (err_cal && any_btn) begin
          err_cal      <= 1'b0;
          load_nominal <= 1'b1;
        end
        if (rc_ff != RC_NONE && cancel_btn) rc_ff <= RC_NONE;
        normal_op <= ~err_cfg & ~err_cal & (rc_ff == RC_NONE);
      end
    end
  end
  assign reset_code = rc_ff;
endmodule // scan_sequencer
`default_nettype wire

// file: bench/scan_seq_props.sv
`timescale 1ns/1ps
`default_nettype none
module scan_seq_props
  import scan_seq_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              arst_n,
  input wire logic              ext_start_n,
  input wire logic              start_btn,
  input wire logic              start_remote,
  input wire logic              scan_arm_state_cmd,
  input wire logic              cancel_btn,
  input wire logic              idle_remote,
  input wire logic              output_on,
  input wire logic              interlock_closed,
  input wire logic [1:0]        output_range,
  input wire logic [1:0]        scan_range,
  input wire logic [VOLT_W-1:0] v_begin,
  input wire logic [VOLT_W-1:0] v_end,
  input wire logic [VOLT_W-1:0] v_out,
  input wire logic              busy_n,
  input wire logic              armed,
  input wire logic              normal_op,
  input wire logic [3:0]        reset_code,
  input wire logic              err_range,
  input wire logic              err_out_off,
  input wire logic              err_equal,
  input wire logic              err_interlock
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire can_arm = busy_n && !armed && normal_op && reset_code == 4'h0;
  wire rng_ok  = output_range == scan_range;
  wire ends_ok = v_begin != v_end;
  wire go      = start_btn || start_remote;
  sequence s_arm_try; scan_arm_state_cmd && can_arm; endsequence
  sequence s_halt; !busy_n && cancel_btn; endsequence
  property p_armed_busy; armed |-> busy_n; endproperty
  a_armed_busy: assert property (p_armed_busy) else $error("busy_n low while armed");
  property p_go; go && armed && !cancel_btn && !idle_remote |=> !busy_n && !armed; endproperty
  a_go: assert property (p_go) else $error("start did not run the scan");
  property p_no_go; go && busy_n && !armed |=> busy_n; endproperty
  a_no_go: assert property (p_no_go) else $error("scan ran while not armed");
  property p_ext;
    $fell(ext_start_n) && armed ##1 (armed && !cancel_btn && !idle_remote)[*2] |-> ##[1:3] !busy_n;
  endproperty
  a_ext: assert property (p_ext) else $error("external edge did not start");
  property p_halt; s_halt |=> busy_n ##1 $stable(v_out)[*4]; endproperty
  a_halt: assert property (p_halt) else $error("halt not clean");
  property p_err_range; s_arm_try ##0 (output_on && ends_ok && !rng_ok) |=> err_range && !armed; endproperty
  a_err_range: assert property (p_err_range) else $error("range mismatch not refused");
  property p_err_off; s_arm_try ##0 (!output_on && ends_ok && rng_ok) |=> err_out_off && !armed; endproperty
  a_err_off: assert property (p_err_off) else $error("output off not refused");
  property p_err_equal; s_arm_try ##0 (output_on && !ends_ok && rng_ok) |=> err_equal && !armed; endproperty
  a_err_equal: assert property (p_err_equal) else $error("equal ends not refused");
  property p_arm_ok; s_arm_try ##0 (output_on && ends_ok && rng_ok) |=> armed && v_out == $past(v_begin); endproperty
  a_arm_ok: assert property (p_arm_ok) else $error("arm failed");
  property p_lock; $fell(interlock_closed) && output_on && output_range == 2'h2 |-> ##[1:2] err_interlock; endproperty
  a_lock: assert property (p_lock) else $error("interlock error missing");
endmodule // scan_seq_props
bind scan_sequencer scan_seq_props u_props (
  .core_clk          (core_clk),
  .arst_n            (arst_n),
  .ext_start_n       (ext_start_n),
  .start_btn         (start_btn),
  .start_remote      (start_remote),
  .scan_arm_state_cmd(scan_arm_state_cmd),
  .cancel_btn        (cancel_btn),
  .idle_remote       (idle_remote),
  .output_on         (output_on),
  .interlock_closed  (interlock_closed),
  .output_range      (output_range),
  .scan_range        (scan_range),
  .v_begin           (v_begin),
  .v_end             (v_end),
  .v_out             (v_out),
  .busy_n            (busy_n),
  .armed             (armed),
  .normal_op         (normal_op),
  .reset_code        (reset_code),
  .err_range         (err_range),
  .err_out_off       (err_out_off),
  .err_equal         (err_equal),
  .err_interlock     (err_interlock)
);
`default_nettype wire

// file: bench/trig_source.sv
`timescale 1ns/1ps
`default_nettype none
module trig_source
  import scan_seq_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic fire,
  output logic      ext_start_n
);
  logic [15:0] low_ff = 16'h0000;
  // The line rests at its pull-up level and is pulled low for the minimum width.
  always @(posedge core_clk) begin
    if (fire) low_ff <= 16'(MIN_TRIG_CYCLES);
    else if (low_ff != 16'h0000) low_ff <= low_ff - 16'h0001;
  end
  assign ext_start_n = (low_ff == 16'h0000);
endmodule // trig_source
`default_nettype wire

// file: bench/test_scan_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_scan_sequencer
  import scan_seq_pkg::*;
;
  localparam int SC = 10;
  localparam int DUR = 64;
  localparam int LIM = DUR * SC * 2 + SC * 4;
  logic core_clk = 0, arst_n = 0, ext_start_n, start_btn = 0, start_remote = 0, scan_arm_state_cmd = 0;
  logic cancel_btn = 0, idle_remote = 0, any_btn = 0, remote_data = 0, output_on = 1, bidir = 0;
  logic repeat_mode = 0, interlock_closed = 1, cal_adjust_req = 0, cal_adjust_ovr = 0, cfg_corrupt = 0;
  logic cal_corrupt = 0, prog_check_ok = 1, selftest_done = 0, fire = 0, busy_n, armed, v_out_en;
  logic err_range, err_out_off, err_equal, err_interlock, err_cfg, err_cal, err_cal_adj, err_prog;
  logic load_defaults, load_nominal, cal_commit, normal_op;
  logic [1:0] output_range = 2'h1, scan_range = 2'h1;
  logic [VOLT_W-1:0] v_begin = 21'h0_0010, v_end = 21'h0_0050, v_step = 21'h0_0001, v_out;
  logic [DUR_W-1:0] duration_ms = 24'h00_0040;
  logic [RS_W-1:0] reset_src = 10'h000;
  logic [3:0] reset_code;
  int n_fail = 0, compares = 0;
  scan_sequencer #(.STEP_CYC(SC)) DUT (.*);
  trig_source u_src (.*);
  always #2 core_clk = ~core_clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results;
    $display("mismatches %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wait_busy(input logic lvl, input int lim, output int n);
    n = 0;
    #1;
    while (busy_n !== lvl) begin
      tick(1);
      n++;
      if (n > lim) begin
        chk(busy_n, lvl, "busy_n_wait");
        results();
      end
    end
  endtask
  task automatic arm(input logic [2:0] e);
    @(posedge core_clk) scan_arm_state_cmd <= 1'b1;
    @(posedge core_clk) scan_arm_state_cmd <= 1'b0;
    #1;
    chk({err_range, err_out_off, err_equal}, e, "arm_err");
    chk(armed, e == 3'b000, "armed");
    if (e == 3'b000) chk(v_out, v_begin, "v_out_begin");
  endtask
  task automatic t_refuse;
    @(posedge core_clk) start_btn <= 1'b1;
    @(posedge core_clk) start_btn <= 1'b0;
    tick(2);
    chk(busy_n, 1'b1, "busy_n_unarmed");
    @(posedge core_clk) output_range <= 2'h2;
    arm(3'b100);
    @(posedge core_clk) begin output_range <= 2'h1; output_on <= 1'b0; end
    arm(3'b010);
    @(posedge core_clk) begin output_on <= 1'b1; v_end <= v_begin; end
    arm(3'b001);
    @(posedge core_clk) v_end <= 21'h0_0050;
  endtask
  task automatic t_single(input logic b);
    int n;
    @(posedge core_clk) bidir <= b;
    arm(3'b000);
    @(posedge core_clk) start_btn <= 1'b1;
    @(posedge core_clk) start_btn <= 1'b0;
    #1;
    chk({busy_n, armed}, 2'b00, "busy_armed");
    wait_busy(1'b1, LIM, n);
    chk(n >= DUR * SC * (int'(b) + 1) - 2 && n <= DUR * SC * (int'(b) + 1) + SC + 2, 1'b1, "run_len");
  endtask
  task automatic t_ext;
    int n;
    @(posedge core_clk) begin fire <= 1'b1; bidir <= 1'b0; end
    @(posedge core_clk) fire <= 1'b0;
    tick(MIN_TRIG_CYCLES + 4);
    chk(busy_n, 1'b1, "busy_n_ext_unarmed");
    arm(3'b000);
    @(posedge core_clk) fire <= 1'b1;
    @(posedge core_clk) fire <= 1'b0;
    wait_busy(1'b0, 6, n);
    tick(MIN_TRIG_CYCLES + 4);
    @(posedge core_clk) fire <= 1'b1;
    @(posedge core_clk) fire <= 1'b0;
    wait_busy(1'b1, LIM, n);
    n = n + MIN_TRIG_CYCLES + 6;
    chk(n >= DUR * SC - 2 && n <= DUR * SC + SC + 4, 1'b1, "ext_run_len");
  endtask
  task automatic t_halt(input logic i);
    logic [VOLT_W-1:0] v;
    @(posedge core_clk) repeat_mode <= 1'b1;
    arm(3'b000);
    @(posedge core_clk) start_remote <= 1'b1;
    @(posedge core_clk) start_remote <= 1'b0;
    tick(DUR * SC * 3);
    chk(busy_n, 1'b0, "busy_n_repeat");
    @(posedge core_clk) begin cancel_btn <= !i; idle_remote <= i; end
    @(posedge core_clk) begin cancel_btn <= 1'b0; idle_remote <= 1'b0; end
    #1;
    v = v_out;
    chk(busy_n, 1'b1, "busy_n_halt");
    tick(3 * SC);
    chk({v_out, v_out_en}, {v, 1'b1}, "v_out_held");
    @(posedge core_clk) repeat_mode <= 1'b0;
  endtask
  task automatic t_interlock;
    @(posedge core_clk) begin output_range <= 2'h2; scan_range <= 2'h2; end
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk) interlock_closed <= 1'b0;
      tick(3);
      chk(err_interlock, 1'b1, "err_interlock");
      @(posedge core_clk) begin interlock_closed <= 1'b1; any_btn <= i == 0; remote_data <= i == 1; end
      @(posedge core_clk) begin any_btn <= 1'b0; remote_data <= 1'b0; end
      tick(2);
      chk(err_interlock, 1'b0, "err_interlock_clr");
    end
  endtask
  task automatic t_cal;
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk) begin cal_adjust_req <= 1'b1; cal_adjust_ovr <= i == 0; end
      @(posedge core_clk) cal_adjust_req <= 1'b0;
      #1;
      chk({err_cal_adj, cal_commit}, {i == 0, i != 0}, "cal_adjust");
    end
  endtask
  // A reset while idle followed by the power-up checks with the given faults and cause.
  task automatic t_power(input logic prog_ok, input logic [RS_W-1:0] src, input logic [3:0] code);
    @(posedge core_clk) begin
      arst_n        <= 1'b0;
      prog_check_ok <= prog_ok;
      cfg_corrupt   <= prog_ok;
      cal_corrupt   <= prog_ok;
      reset_src     <= src;
    end
    tick(2);
    chk({busy_n, armed, normal_op, reset_code}, {3'b100, 4'h0}, "reset_state");
    @(posedge core_clk) arst_n <= 1'b1;
    @(posedge core_clk) selftest_done <= 1'b1;
    @(posedge core_clk) selftest_done <= 1'b0;
    tick(3);
    chk({err_prog, err_cfg, err_cal, normal_op}, {~prog_ok, prog_ok, prog_ok, 1'b0}, "power_errs");
    chk(reset_code, code, "reset_code");
    @(posedge core_clk) any_btn <= 1'b1;
    @(posedge core_clk) any_btn <= 1'b0;
    #1;
    chk({load_defaults, load_nominal, err_cfg, err_cal}, {prog_ok, prog_ok, 2'b00}, "defaults_load");
    chk({reset_code, normal_op}, {code, 1'b0}, "code_holds");
    @(posedge core_clk) cancel_btn <= 1'b1;
    @(posedge core_clk) cancel_btn <= 1'b0;
    tick(2);
    chk({reset_code, normal_op}, {prog_ok ? 4'h0 : code, prog_ok}, "code_cleared");
    if (!prog_ok) begin
      @(posedge core_clk) scan_arm_state_cmd <= 1'b1;
      @(posedge core_clk) scan_arm_state_cmd <= 1'b0;
      #1;
      chk(armed, 1'b0, "armed_prog_bad");
    end
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk) selftest_done <= 1'b1;
    @(posedge core_clk) selftest_done <= 1'b0;
    tick(3);
    chk({normal_op, busy_n}, 2'b11, "normal_idle");
    t_refuse;
    t_single(1'b0);
    t_single(1'b1);
    t_ext;
    t_halt(1'b0);
    t_halt(1'b1);
    t_interlock;
    t_cal;
    t_power(1'b0, 10'h040, 4'hA);
    t_power(1'b1, 10'h004, 4'h3);
    results;
  end
endmodule // test_scan_sequencer
`default_nettype wire
